// [src/tcm_defines.svh]
// register offsets, field positions and reset values of the timer block
`ifndef TCM_DEFINES_SVH
`define TCM_DEFINES_SVH
`define TCM_A_CTRL 8'h00
`define TCM_A_TC 8'h04
`define TCM_A_PR 8'h08
`define TCM_A_PC 8'h0c
`define TCM_A_MCR 8'h10
`define TCM_A_MR0 8'h14
`define TCM_A_MR1 8'h18
`define TCM_A_MR2 8'h1c
`define TCM_A_MR3 8'h20
`define TCM_A_CCR 8'h24
`define TCM_A_CR0 8'h28
`define TCM_A_CR1 8'h2c
`define TCM_A_CR2 8'h30
`define TCM_A_CR3 8'h34
`define TCM_A_EMC 8'h38
`define TCM_A_EM 8'h3c
`define TCM_A_IST 8'h40
`define TCM_A_ICLR 8'h44
`define TCM_A_IEN 8'h48
`define TCM_A_CMASK 8'h4c
`define TCM_A_CAND 8'h50
`define TCM_A_MSEL 8'h54
`define TCM_CTRL_EN 0
`define TCM_CTRL_CRST 1
`define TCM_CTRL_MODE 3:2
`define TCM_CTRL_SRC 5:4
`define TCM_IST_MAT 3:0
`define TCM_IST_CAP 7:4
`define TCM_NCH 4
`define TCM_NPIN 8
`define TCM_CTRL_RV 6'h00
`define TCM_B8_RV 8'h00
`define TCM_B4_RV 4'h0
`define TCM_B16_RV 16'h0000
`define TCM_W_RV 32'h0000_0000
`define TCM_ONE32 32'h0000_0001
`endif

// [src/tcm_pinmux.sv]
// pin routing: capture pins combine by or/and, match outputs broadcast to pins
`timescale 1ns/10ps
`default_nettype none
`include "tcm_defines.svh"
module tcm_pinmux (
    input wire logic [7:0] cap_pins_i,
    input wire logic [31:0] mask_i,
    input wire logic [3:0] and_i,
    input wire logic [3:0] em_i,
    input wire logic [15:0] msel_i,
    output logic [3:0] cap_o,
    output logic [7:0] mat_o
);
    always_comb begin
        for (int i = 0; i < `TCM_NCH; i++) begin
            if (and_i[i]) begin
                cap_o[i] = (|mask_i[8*i +: 8]) && (&(cap_pins_i | ~mask_i[8*i +: 8])); // R13
            end else begin
                cap_o[i] = |(cap_pins_i & mask_i[8*i +: 8]); // R13
            end
        end
        for (int p = 0; p < `TCM_NPIN; p++) begin
            mat_o[p] = em_i[msel_i[2*p +: 2]]; // R13
        end
    end
endmodule : tcm_pinmux
`default_nettype wire

// [src/tcm_pkg.sv]
// types shared by the timer block
`default_nettype none
package tcm_pkg;
    typedef enum logic [1:0] {MODE_TIMER, MODE_RISE, MODE_FALL, MODE_BOTH} tcm_mode_t;
    typedef enum logic [1:0] {EM_KEEP, EM_LOW, EM_HIGH, EM_TOGGLE} tcm_emact_t;
    typedef struct packed {
        logic stop;
        logic rst;
    } tcm_mcfg_t;
    typedef struct packed {
        logic fall;
        logic rise;
    } tcm_ccfg_t;
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [7:0] adr;
        logic [31:0] dat;
    } tcm_wbreq_t;
endpackage : tcm_pkg
`default_nettype wire

// [src/tcm_prescale.sv]
// 32-bit prescale counter that wraps at the programmed limit
`timescale 1ns/10ps
`default_nettype none
`include "tcm_defines.svh"
module tcm_prescale (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic tick_i,
    input wire logic clr_i,
    input wire logic [31:0] limit_i,
    output logic [31:0] count_o,
    output logic wrap_o
);
    assign wrap_o = tick_i && !clr_i && (count_o == limit_i); // R14

    always_ff @(posedge clk_i) begin
        if (rst_i || clr_i) begin
            count_o <= `TCM_W_RV;
        end else if (wrap_o) begin
            count_o <= `TCM_W_RV; // R14
        end else if (tick_i) begin
            count_o <= count_o + `TCM_ONE32; // R1
        end
    end
endmodule : tcm_prescale
`default_nettype wire

// [src/tcm_timer.sv]
// timer/counter with prescaler, capture, match and wishbone registers
// Contract
// R1: a 32-bit counter advances through a programmable 32-bit prescaler.
// R2: the counter counts clock cycles or edges of an external input, by mode.
// R3: in event mode exactly one routed capture input is the count source.
// R4: external events must come no faster than half the clock rate.
// R5: capture inputs not used as count source still capture normally.
// R6: four 32-bit capture registers snapshot the counter on an input edge.
// R7: each capture event can raise an interrupt when enabled.
// R8: four 32-bit match registers are compared against the counter.
// R9: a match may let the counter run on, with optional interrupt.
// R10: a match may stop the counter, with optional interrupt.
// R11: a match may reset the counter, with optional interrupt.
// R12: each match output goes low, high, toggles or holds on its match.
// R13: several pins may feed one capture or carry one match, as or/and/broadcast.
// R14: the counter steps when the prescaler reaches its limit and wraps to zero.
//
// Register access over Wishbone and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "tcm_defines.svh"
module tcm_timer (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [7:0] cap_pins_i,
    output logic [7:0] mat_pins_o,
    output logic irq_o
);
    tcm_pkg::tcm_wbreq_t req;
    logic [5:0] ctrl_r;
    logic [31:0] tc_r;
    logic [31:0] pr_r;
    logic [7:0] mcr_r;
    logic [31:0] mr_r [4];
    logic [7:0] ccr_r;
    logic [31:0] cr_r [4];
    logic [7:0] emc_r;
    logic [3:0] em_r;
    logic [3:0] em_nxt;
    logic [7:0] ist_r;
    logic [7:0] ist_nxt;
    logic [7:0] ien_r;
    logic [31:0] cmask_r;
    logic [3:0] cand_r;
    logic [15:0] msel_r;
    logic [3:0] cap_prev_r;
    logic [3:0] cap_sig;
    logic [7:0] mat_sig;
    logic [31:0] pc;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic [7:0] iclr;
    logic [3:0] hit;
    logic [3:0] rst_hit;
    logic [3:0] stop_hit;
    logic [3:0] cap_rise;
    logic [3:0] cap_fall;
    logic [3:0] cap_evt;
    logic src_now;
    logic src_prev;
    logic src_edge;
    logic tick;
    logic ps_wrap;
    logic acc;
    logic wr;
    tcm_pkg::tcm_mode_t mode;
    tcm_pkg::tcm_mcfg_t mcfg [4];
    tcm_pkg::tcm_ccfg_t ccfg [4];
    tcm_pkg::tcm_emact_t emact [4];

    function automatic logic [31:0] f_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return res;
    endfunction : f_merge

    function automatic logic f_wr(input logic w, input logic [7:0] adr, input logic [7:0] a);
        return w && ({adr[7:2], 2'h0} == a);
    endfunction : f_wr

    // wishbone slave: ack one cycle after the request, writes commit with ack
    assign req = '{wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i, wb_adr_i, wb_dat_i};
    assign acc = req.cyc && req.stb;
    assign wr = acc && req.we && wb_ack_o;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= acc && !wb_ack_o;
        end
    end

    always_comb begin
        unique case ({req.adr[7:2], 2'h0})
            `TCM_A_CTRL: rdat = {26'h0, ctrl_r};
            `TCM_A_TC: rdat = tc_r;
            `TCM_A_PR: rdat = pr_r;
            `TCM_A_PC: rdat = pc;
            `TCM_A_MCR: rdat = {24'h0, mcr_r};
            `TCM_A_MR0: rdat = mr_r[0];
            `TCM_A_MR1: rdat = mr_r[1];
            `TCM_A_MR2: rdat = mr_r[2];
            `TCM_A_MR3: rdat = mr_r[3];
            `TCM_A_CCR: rdat = {24'h0, ccr_r};
            `TCM_A_CR0: rdat = cr_r[0];
            `TCM_A_CR1: rdat = cr_r[1];
            `TCM_A_CR2: rdat = cr_r[2];
            `TCM_A_CR3: rdat = cr_r[3];
            `TCM_A_EMC: rdat = {24'h0, emc_r};
            `TCM_A_EM: rdat = {28'h0, em_r};
            `TCM_A_IST: rdat = {24'h0, ist_r};
            `TCM_A_IEN: rdat = {24'h0, ien_r};
            `TCM_A_CMASK: rdat = cmask_r;
            `TCM_A_CAND: rdat = {28'h0, cand_r};
            `TCM_A_MSEL: rdat = {16'h0, msel_r};
            default: rdat = `TCM_W_RV;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= `TCM_W_RV;
        end else if (acc && !wb_ack_o) begin
            wb_dat_o <= rdat;
        end
    end

    // configuration registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pr_r <= `TCM_W_RV;
            mcr_r <= `TCM_B8_RV;
            ccr_r <= `TCM_B8_RV;
            emc_r <= `TCM_B8_RV;
            ien_r <= `TCM_B8_RV;
            cmask_r <= `TCM_W_RV;
            cand_r <= `TCM_B4_RV;
            msel_r <= `TCM_B16_RV;
            for (int i = 0; i < `TCM_NCH; i++) begin
                mr_r[i] <= `TCM_W_RV;
            end
        end else begin
            if (f_wr(wr, req.adr, `TCM_A_PR)) pr_r <= f_merge(pr_r, req.dat, req.sel);
            if (f_wr(wr, req.adr, `TCM_A_MCR)) mcr_r <= wdat[7:0];
            if (f_wr(wr, req.adr, `TCM_A_CCR)) ccr_r <= wdat[7:0];
            if (f_wr(wr, req.adr, `TCM_A_EMC)) emc_r <= wdat[7:0];
            if (f_wr(wr, req.adr, `TCM_A_IEN)) ien_r <= wdat[7:0];
            if (f_wr(wr, req.adr, `TCM_A_CMASK)) cmask_r <= wdat;
            if (f_wr(wr, req.adr, `TCM_A_CAND)) cand_r <= wdat[3:0];
            if (f_wr(wr, req.adr, `TCM_A_MSEL)) msel_r <= wdat[15:0];
            if (f_wr(wr, req.adr, `TCM_A_MR0)) mr_r[0] <= f_merge(mr_r[0], req.dat, req.sel);
            if (f_wr(wr, req.adr, `TCM_A_MR1)) mr_r[1] <= f_merge(mr_r[1], req.dat, req.sel);
            if (f_wr(wr, req.adr, `TCM_A_MR2)) mr_r[2] <= f_merge(mr_r[2], req.dat, req.sel);
            if (f_wr(wr, req.adr, `TCM_A_MR3)) mr_r[3] <= f_merge(mr_r[3], req.dat, req.sel);
        end
    end

    assign wdat = f_merge(rdat, req.dat, req.sel);
    assign iclr = f_wr(wr, req.adr, `TCM_A_ICLR) ? (req.dat[7:0] & {8{req.sel[0]}}) : 8'h00;

    // control: enable, counter reset, mode, count source; a stop match wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r <= `TCM_CTRL_RV;
        end else begin
            if (f_wr(wr, req.adr, `TCM_A_CTRL)) begin
                ctrl_r <= wdat[5:0];
            end
            if (|stop_hit) begin
                ctrl_r[`TCM_CTRL_EN] <= 1'b0; // R10
            end
        end
    end

    // pin routing
    tcm_pinmux u_pinmux (
        .cap_pins_i(cap_pins_i),
        .mask_i(cmask_r),
        .and_i(cand_r),
        .em_i(em_r),
        .msel_i(msel_r),
        .cap_o(cap_sig),
        .mat_o(mat_sig)
    );

    // edges of routed capture inputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cap_prev_r <= `TCM_B4_RV;
        end else begin
            cap_prev_r <= cap_sig;
        end
    end

    always_comb begin
        for (int i = 0; i < `TCM_NCH; i++) begin
            mcfg[i] = tcm_pkg::tcm_mcfg_t'(mcr_r[2*i +: 2]);
            ccfg[i] = tcm_pkg::tcm_ccfg_t'(ccr_r[2*i +: 2]);
            emact[i] = tcm_pkg::tcm_emact_t'(emc_r[2*i +: 2]);
        end
    end

    assign cap_rise = cap_sig & ~cap_prev_r;
    assign cap_fall = ~cap_sig & cap_prev_r;
    assign mode = tcm_pkg::tcm_mode_t'(ctrl_r[`TCM_CTRL_MODE]);
    assign src_now = cap_sig[ctrl_r[`TCM_CTRL_SRC]]; // R3
    assign src_prev = cap_prev_r[ctrl_r[`TCM_CTRL_SRC]]; // R3

    always_comb begin
        unique case (mode)
            tcm_pkg::MODE_TIMER: src_edge = 1'b1; // R2
            tcm_pkg::MODE_RISE: src_edge = src_now && !src_prev; // R2
            tcm_pkg::MODE_FALL: src_edge = !src_now && src_prev; // R2
            tcm_pkg::MODE_BOTH: src_edge = src_now != src_prev; // R2 R4
        endcase
    end

    assign tick = ctrl_r[`TCM_CTRL_EN] && !ctrl_r[`TCM_CTRL_CRST] && src_edge;

    tcm_prescale u_prescale (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(tick),
        .clr_i(ctrl_r[`TCM_CTRL_CRST]),
        .limit_i(pr_r),
        .count_o(pc),
        .wrap_o(ps_wrap)
    );

    // match compare, sampled as the counter is about to step
    always_comb begin
        for (int i = 0; i < `TCM_NCH; i++) begin
            hit[i] = ps_wrap && (tc_r == mr_r[i]); // R8 R9
            rst_hit[i] = hit[i] && mcfg[i].rst; // R11
            stop_hit[i] = hit[i] && mcfg[i].stop; // R10
            cap_evt[i] = (ccfg[i].rise && cap_rise[i]) || (ccfg[i].fall && cap_fall[i]); // R5 R6
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tc_r <= `TCM_W_RV;
        end else if (ctrl_r[`TCM_CTRL_CRST]) begin
            tc_r <= `TCM_W_RV;
        end else if (f_wr(wr, req.adr, `TCM_A_TC)) begin
            tc_r <= f_merge(tc_r, req.dat, req.sel);
        end else if (|rst_hit) begin
            tc_r <= `TCM_W_RV; // R11
        end else if (ps_wrap) begin
            tc_r <= tc_r + `TCM_ONE32; // R1 R14
        end
    end

    // capture snapshots
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < `TCM_NCH; i++) begin
                cr_r[i] <= `TCM_W_RV;
            end
        end else begin
            for (int i = 0; i < `TCM_NCH; i++) begin
                if (cap_evt[i]) cr_r[i] <= tc_r; // R6
            end
        end
    end

    // external match states; a low, high or toggle match overrides a bus write in the same cycle
    always_comb begin
        em_nxt = f_wr(wr, req.adr, `TCM_A_EM) ? wdat[3:0] : em_r;
        for (int i = 0; i < `TCM_NCH; i++) begin
            if (hit[i]) begin
                unique case (emact[i])
                    tcm_pkg::EM_KEEP: em_nxt[i] = em_nxt[i]; // R12
                    tcm_pkg::EM_LOW: em_nxt[i] = 1'b0; // R12
                    tcm_pkg::EM_HIGH: em_nxt[i] = 1'b1; // R12
                    tcm_pkg::EM_TOGGLE: em_nxt[i] = !em_r[i]; // R12
                endcase
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            em_r <= `TCM_B4_RV;
            mat_pins_o <= `TCM_B8_RV;
        end else begin
            em_r <= em_nxt;
            mat_pins_o <= mat_sig; // R13
        end
    end

    // sticky status, set wins over clear; enabled bits drive the interrupt
    assign ist_nxt = (ist_r & ~iclr) | {cap_evt, hit}; // R7 R9

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ist_r <= `TCM_B8_RV;
            irq_o <= 1'b0;
        end else begin
            ist_r <= ist_nxt;
            irq_o <= |(ist_r & ien_r); // R7 R9 R10 R11
        end
    end

    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_req;
        acc && !wb_ack_o;
    endsequence
    sequence s_ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    wb_ack_pulse_a: assert property (s_req |=> s_ack_pulse)
        else $error("ack is not a one cycle pulse after a request");
    presc_wrap_a: assert property (tick && pc == pr_r && !ctrl_r[`TCM_CTRL_CRST] |=> pc == 0) // R14
        else $error("prescaler did not wrap at its limit");
    tc_step_a: assert property (ps_wrap && !(|rst_hit) && !ctrl_r[`TCM_CTRL_CRST] // R14
        && !f_wr(wr, req.adr, `TCM_A_TC) |=> tc_r == $past(tc_r) + 1)
        else $error("counter did not step on prescaler wrap");
    tc_hold_a: assert property (!ps_wrap && !(|rst_hit) && !ctrl_r[`TCM_CTRL_CRST] // R1
        && !f_wr(wr, req.adr, `TCM_A_TC) |=> $stable(tc_r))
        else $error("counter moved without a prescaler wrap");
    event_gate_a: assert property (mode != tcm_pkg::MODE_TIMER && src_now == src_prev // R2
        |-> !tick)
        else $error("event mode counted without a source edge");
    stop_match_a: assert property (|stop_hit |=> !ctrl_r[`TCM_CTRL_EN] ##1 $stable(tc_r)) // R10
        else $error("stop on match did not halt the counter");
    reset_match_a: assert property (|rst_hit && !ctrl_r[`TCM_CTRL_CRST] // R11
        && !f_wr(wr, req.adr, `TCM_A_TC) |=> tc_r == 0)
        else $error("reset on match did not clear the counter");
    cap_snap_a: assert property (cap_evt[1] |=> cr_r[1] == $past(tc_r)) // R6
        else $error("capture did not store the counter value");
    em_toggle_a: assert property (hit[3] && emact[3] == tcm_pkg::EM_TOGGLE // R12
        |=> em_r[3] != $past(em_r[3]) ##1 mat_pins_o == $past(mat_sig))
        else $error("toggle on match did not toggle the match output");
    irq_level_a: assert property (|(ist_r & ien_r) |=> irq_o) // R7 R9
        else $error("enabled status bit did not raise the interrupt");
    status_sticky_a: assert property (ist_r[0] && !iclr[0] |=> ist_r[0]) // R9
        else $error("status bit dropped without a clear");
endmodule : tcm_timer
`default_nettype wire

// [verif/tcm_pins_model.sv]
// capture pin driver standing in for the external event sources
`timescale 1ns/10ps
`default_nettype none
module tcm_pins_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] toggle_i,
    output logic [7:0] pins_o
);
    logic [7:0] pend_r;
    logic gap_r;
    // toggles wait for a free slot, so pins change at most every other cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pins_o <= 8'h00;
            pend_r <= 8'h00;
            gap_r <= 1'b0;
        end else if (!gap_r && (pend_r | toggle_i) != 8'h00) begin
            pins_o <= pins_o ^ (pend_r | toggle_i);
            pend_r <= 8'h00;
            gap_r <= 1'b1;
        end else begin
            pend_r <= pend_r | toggle_i;
            gap_r <= 1'b0;
        end
    end
endmodule : tcm_pins_model
`default_nettype wire

// [verif/tcm_timer_tb.sv]
// self-checking testbench of the timer block
`timescale 1ns/10ps
`default_nettype none
`include "tcm_defines.svh"
module tcm_timer_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [3:0] sel = 4'h0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [7:0] tog = 8'h00;
    logic [7:0] cap_pins;
    logic [7:0] mat_pins_o;
    logic irq_o;
    int err_count = 0;
    int checks = 0;
    int cyc_n = 0;
    logic [31:0] v, t0, t1;

    tcm_timer u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .cap_pins_i(cap_pins), .mat_pins_o(mat_pins_o), .irq_o(irq_o));
    tcm_pins_model u_pins (.clk_i(clk_i), .rst_i(rst_i), .toggle_i(tog), .pins_o(cap_pins));

    always #10 clk_i = ~clk_i;

    task automatic close_out;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out

    always @(posedge clk_i) begin
        cyc_n++;
        if (cyc_n >= 20000) begin
            err_count++;
            close_out();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'hf;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        r = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk_i);
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, r);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        xfer(1'b0, a, 32'h0, r);
    endtask : rd

    task automatic pulse(input int p);
        @(posedge clk_i);
        tog <= 8'h01 << p;
        @(posedge clk_i);
        tog <= 8'h00;
        tick(4);
    endtask : pulse

    task automatic t_reset;
        rd(`TCM_A_CTRL, v);
        check(v, 32'h0);
        rd(8'h80, v);
        check(v, 32'h0);
        wr(`TCM_A_PR, 32'hffff_ffff);
        rd(`TCM_A_PR, v);
        check(v, 32'hffff_ffff);
        wr(`TCM_A_PR, 32'h0);
        wr(`TCM_A_MR3, 32'hffff_fffe);
        rd(`TCM_A_MR3, v);
        check(v, 32'hffff_fffe);
    endtask : t_reset

    task automatic t_stop;
        wr(`TCM_A_PR, 32'h3);
        wr(`TCM_A_TC, 32'h0);
        wr(`TCM_A_MR0, 32'h5);
        wr(`TCM_A_MCR, 32'h2);
        wr(`TCM_A_CTRL, 32'h1);
        rd(`TCM_A_PC, v);
        check({31'h0, v <= 32'h3}, 32'h1);
        tick(60);
        rd(`TCM_A_CTRL, v);
        check(v, 32'h0);
        rd(`TCM_A_TC, v);
        check(v, 32'h6);
        rd(`TCM_A_IST, v);
        check(v & 32'h1, 32'h1);
        wr(`TCM_A_ICLR, 32'hff);
        wr(`TCM_A_PR, 32'h0);
    endtask : t_stop

    task automatic t_runon;
        wr(`TCM_A_MCR, 32'h0);
        wr(`TCM_A_TC, 32'h0);
        wr(`TCM_A_MR1, 32'h14);
        wr(`TCM_A_CTRL, 32'h1);
        tick(40);
        rd(`TCM_A_IST, v);
        check(v & 32'h2, 32'h2);
        check({31'h0, irq_o}, 32'h0);
        rd(`TCM_A_TC, v);
        check({31'h0, v > 32'h15}, 32'h1);
        wr(`TCM_A_IEN, 32'h2);
        tick(2);
        check({31'h0, irq_o}, 32'h1);
        wr(`TCM_A_ICLR, 32'h2);
        tick(2);
        check({31'h0, irq_o}, 32'h0);
        wr(`TCM_A_CTRL, 32'h0);
        wr(`TCM_A_IEN, 32'h0);
    endtask : t_runon

    task automatic t_rstmatch;
        wr(`TCM_A_TC, 32'h0);
        wr(`TCM_A_MR0, 32'h9);
        wr(`TCM_A_MCR, 32'h1);
        wr(`TCM_A_CTRL, 32'h1);
        for (int i = 0; i < 4; i++) begin
            rd(`TCM_A_TC, v);
            check({31'h0, v <= 32'h9}, 32'h1);
            tick(7);
        end
        rd(`TCM_A_IST, v);
        check(v & 32'h1, 32'h1);
        wr(`TCM_A_CTRL, 32'h0);
        wr(`TCM_A_ICLR, 32'hff);
    endtask : t_rstmatch

    task automatic t_extmatch;
        wr(`TCM_A_TC, 32'h0);
        wr(`TCM_A_EM, 32'h5);
        wr(`TCM_A_EMC, 32'he4);
        wr(`TCM_A_MSEL, 32'hffe4);
        for (int i = 0; i < 4; i++) wr(8'(`TCM_A_MR0 + 4 * i), 32'h2);
        wr(`TCM_A_MCR, 32'h2);
        tick(2);
        check({24'h0, mat_pins_o}, 32'h05);
        wr(`TCM_A_CTRL, 32'h1);
        tick(20);
        rd(`TCM_A_EM, v);
        check(v, 32'hd);
        check({24'h0, mat_pins_o}, 32'hfd);
        wr(`TCM_A_MCR, 32'h0);
        wr(`TCM_A_ICLR, 32'hff);
    endtask : t_extmatch

    task automatic t_capture;
        wr(`TCM_A_CMASK, 32'h0010_0c03);
        wr(`TCM_A_CAND, 32'h2);
        wr(`TCM_A_CCR, 32'h05);
        wr(`TCM_A_IEN, 32'h10);
        wr(`TCM_A_TC, 32'h0);
        wr(`TCM_A_CTRL, 32'h1);
        rd(`TCM_A_TC, t0);
        pulse(1);
        rd(`TCM_A_CR0, v);
        rd(`TCM_A_TC, t1);
        check({31'h0, v > t0 && v < t1}, 32'h1);
        rd(`TCM_A_IST, v);
        check(v & 32'hf0, 32'h10);
        check({31'h0, irq_o}, 32'h1);
        pulse(2);
        rd(`TCM_A_CR1, v);
        check(v, 32'h0);
        pulse(3);
        rd(`TCM_A_CR1, v);
        check({31'h0, v != 32'h0}, 32'h1);
        pulse(1);
        wr(`TCM_A_CTRL, 32'h0);
        wr(`TCM_A_IEN, 32'h0);
        wr(`TCM_A_ICLR, 32'hff);
    endtask : t_capture

    task automatic t_event;
        wr(`TCM_A_TC, 32'h0);
        wr(`TCM_A_CTRL, 32'h25);
        for (int i = 0; i < 6; i++) pulse(4);
        rd(`TCM_A_TC, v);
        check(v, 32'h3);
        wr(`TCM_A_CTRL, 32'h2d);
        pulse(4);
        pulse(4);
        rd(`TCM_A_TC, v);
        check(v, 32'h5);
        pulse(0);
        rd(`TCM_A_CR0, v);
        check(v, 32'h5);
        wr(`TCM_A_CTRL, 32'h29);
        pulse(4);
        pulse(4);
        rd(`TCM_A_TC, v);
        check(v, 32'h6);
        wr(`TCM_A_CTRL, 32'h02);
        tick(3);
        rd(`TCM_A_TC, v);
        check(v, 32'h0);
        rd(`TCM_A_PC, v);
        check(v, 32'h0);
        wr(`TCM_A_CTRL, 32'h0);
    endtask : t_event

    initial begin
        tick(16);
        rst_i <= 1'b0;
        t_reset();
        t_stop();
        t_runon();
        t_rstmatch();
        t_extmatch();
        t_capture();
        t_event();
        close_out();
    end
endmodule : tcm_timer_tb
`default_nettype wire
